// ### common/tpw_pkg.sv
// Types shared by the three-phase PWM timing unit modules.
package tpw_pkg;

  // State of the top module apart from the reset pipe, registered as one word.
  typedef struct packed {
    logic             wb_ack;
    logic [15:0]      wb_dat;
    logic             dbl;
    logic [15:0]      tm;
    logic [9:0]       dt;
    logic [15:0]      mp;
    logic [7:0]       sw;
    logic [2:0][15:0] duty;
    logic [8:0]       steer;
    logic [3:0]       written;
    logic             tmr_on;
    logic [17:0]      st_cnt;
    logic             run;
    logic [15:0]      cnt;
    logic             half;
    logic             fire;
    logic [15:0]      a_tm;
    logic [9:0]       a_dt;
    logic [15:0]      a_mp;
    logic [7:0]       a_sw;
    logic [2:0][15:0] a_duty;
    logic [8:0]       a_steer;
  } tpw_state_t;

  // State of one phase comparator.
  typedef struct packed {
    logic hi;
    logic lo;
  } tpw_phase_st_t;

  // State of the sync pulse generator.
  typedef struct packed {
    logic [8:0] cnt;
    logic       pulse;
    logic       irq;
  } tpw_sync_st_t;

endpackage

// ### common/tpw_regs.svh
// Register offsets, field positions and reset values of the three-phase PWM timing unit.
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// Byte offsets on the Wishbone bus, one aligned 32-bit word each.
`define TPW_OFF_MODE      8'h00
`define TPW_OFF_HALF_PER  8'h04
`define TPW_OFF_DEAD      8'h08
`define TPW_OFF_MIN_PULSE 8'h0C
`define TPW_OFF_SYNC_W    8'h10
`define TPW_OFF_DUTY_A    8'h14
`define TPW_OFF_DUTY_B    8'h18
`define TPW_OFF_DUTY_C    8'h1C
`define TPW_OFF_STEER     8'h20
`define TPW_OFF_STATUS    8'h24

// Field positions.
`define TPW_MODE_DBL_BIT  6
`define TPW_STAT_RUN_BIT  0
`define TPW_STAT_HALF_BIT 3

// Bit index of each "written once" flag.
`define TPW_WR_TM 0
`define TPW_WR_A  1
`define TPW_WR_B  2
`define TPW_WR_C  3

// Sync width reset value and dead-time count maximum.
`define TPW_SYNC_W_RST 8'h27
`define TPW_DT_MAX     10'h3FF

// Clocks from the start-delay compare to the sync rise, taken off the start delay.
`define TPW_START_LAT  18'h00002

`endif

// ### design/tpw_phase.sv
// One complementary output pair with dead time, compared against the sweep counter.
`timescale 1ns/1ps
module tpw_phase
  import tpw_pkg::*;
#(
  parameter int CW = 16,
  parameter int DW = 10
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          run,
  input  wire logic [CW-1:0] cnt,
  input  wire logic [CW-1:0] tm,
  input  wire logic [CW-1:0] duty,
  input  wire logic [DW-1:0] dt,
  output logic               high_q,
  output logic               low_q
);

  tpw_phase_st_t s_q;
  tpw_phase_st_t s_d;
  logic signed [CW+1:0] hi_thr;
  logic signed [CW+1:0] lo_thr;
  logic signed [CW+1:0] pos;

  // Both edges move by dt from the duty instant, so the gap between them is 2*dt.
  assign hi_thr = $signed({2'b00, tm}) - $signed({2'b00, duty}) + $signed({{(CW+2-DW){1'b0}}, dt}); // [RULE1] [RULE13]
  assign lo_thr = $signed({2'b00, tm}) - $signed({2'b00, duty}) - $signed({{(CW+2-DW){1'b0}}, dt}); // [RULE1] [RULE14]
  assign pos    = $signed({2'b00, cnt});

  // Out-of-range thresholds saturate to always on or always off, which clamps the on-time.
  always_comb begin
    s_d    = s_q;
    s_d.hi = run & (pos >= hi_thr); // [RULE12] [RULE15] [RULE22]
    s_d.lo = run & (pos < lo_thr);  // [RULE3] [RULE15] [RULE22]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign high_q = s_q.hi;
  assign low_q  = s_q.lo;

endmodule

// ### design/tpw_sync_gen.sv
// Period sync pulse of programmable width, plus a one-cycle interrupt request.
`timescale 1ns/1ps
module tpw_sync_gen
  import tpw_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  output logic            sync_q,
  output logic            irq_q
);

  tpw_sync_st_t s_q;
  tpw_sync_st_t s_d;

  // A new fire restarts the pulse; the width must be shorter than a half period.
  always_comb begin
    s_d     = s_q;
    s_d.irq = fire; // [RULE21]
    if (fire) begin
      s_d.pulse = 1'b1;
      s_d.cnt   = {1'b0, width}; // [RULE10]
    end else if (s_q.cnt != 9'h000) begin
      s_d.cnt = s_q.cnt - 9'h001;
    end else begin
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_q = s_q.pulse;
  assign irq_q  = s_q.irq;

endmodule

// ### design/tpw_timing_unit.sv
// Three-phase centre-based PWM timing unit with a classic Wishbone register slave.
//
// Contract
// [RULE1] Dead time is count times two clocks.
// [RULE2] Dead-time count is ten bits, max 0x3FF.
// [RULE3] Zero dead time switches pairs without delay.
// [RULE4] Mode bit 6 selects single or double update.
// [RULE5] Reset clears mode bit: single update default.
// [RULE6] Period-start sync edge loads all timing values.
// [RULE7] Every sync edge also loads output steering.
// [RULE8] Double mode adds midpoint sync that reloads.
// [RULE9] Status bit 3 marks second half.
// [RULE10] Sync pulse lasts width count plus one.
// [RULE11] Sync width resets to 0x27.
// [RULE12] Each duty sets its own high-side on-time.
// [RULE13] Centre-based; every edge shifted by dead time.
// [RULE14] Single mode on-times follow duty minus dead.
// [RULE15] On-times clamp between zero and full period.
// [RULE16] Double mode sums both halves' values.
// [RULE17] Nothing runs until period and duties written.
// [RULE18] First sync delayed after first period write.
// [RULE19] Period register counts clocks per half period.
// [RULE20] Half-period register is sixteen bits.
// [RULE21] Interrupt request on every sync pulse.
// [RULE22] Counter sweeps zero to period, compared.
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_timing_unit
  import tpw_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  output logic               phase_a_high_out,
  output logic               phase_a_low_out,
  output logic               phase_b_high_out,
  output logic               phase_b_low_out,
  output logic               phase_c_high_out,
  output logic               phase_c_low_out,
  output logic               period_sync_pulse,
  output logic               sync_irq,
  output logic [8:0]         steer_active
);

  logic [1:0] rst_pipe_q;
  logic       rst_sync_n;
  tpw_state_t s_q;
  tpw_state_t s_d;
  logic       acc;
  logic       wr;
  logic [15:0] wval;
  logic [17:0] target;
  logic [2:0] hi_w;
  logic [2:0] lo_w;

  // Merge a write into a 16-bit register by its two low byte lanes.
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] dat,
                                       input logic [3:0]  sel);
    logic [15:0] r;
    r[15:8] = sel[1] ? dat[15:8] : old[15:8];
    r[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
    return r;
  endfunction

  // Copy the software-visible set into the working set at a sync edge.
  function automatic tpw_state_t load_cfg(input tpw_state_t s);
    tpw_state_t r;
    r         = s;
    r.a_tm    = s.tm;
    r.a_dt    = s.dt;
    r.a_mp    = s.mp;
    r.a_sw    = s.sw;
    r.a_duty  = s.duty;
    r.a_steer = s.steer;
    return r;
  endfunction

  // Reset is released through two flops so that its removal is clean against clk_sys.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_q[1];

  // A request is taken only once; the registered ack then blocks a second take.
  assign acc  = wb_cyc_i & wb_stb_i & ~s_q.wb_ack;
  assign wr   = acc & wb_we_i;
  assign wval = wb_dat_i[15:0];

  // The start delay is measured from the first half-period write; the compare-to-sync
  // latency is taken off so that the sync rise lands on the documented instant.
  assign target = (s_q.dbl ? {2'b00, s_q.tm} :
                   ({2'b00, s_q.tm} + {3'b000, s_q.tm[15:1]})) - `TPW_START_LAT; // [RULE18]

  // Register slave, start-up sequencing and the half-period sweep counter.
  always_comb begin
    s_d        = s_q;
    s_d.fire   = 1'b0;
    s_d.wb_ack = acc;
    s_d.wb_dat = 16'h0000;

    // Register reads; unmapped offsets read as zero.
    if (acc) begin
      case (wb_adr_i)
        `TPW_OFF_MODE: begin
          s_d.wb_dat[`TPW_MODE_DBL_BIT] = s_q.dbl;
        end
        `TPW_OFF_HALF_PER: begin
          s_d.wb_dat = s_q.tm;
        end
        `TPW_OFF_DEAD: begin
          s_d.wb_dat = {6'h00, s_q.dt};
        end
        `TPW_OFF_MIN_PULSE: begin
          s_d.wb_dat = s_q.mp;
        end
        `TPW_OFF_SYNC_W: begin
          s_d.wb_dat = {8'h00, s_q.sw};
        end
        `TPW_OFF_DUTY_A: begin
          s_d.wb_dat = s_q.duty[0];
        end
        `TPW_OFF_DUTY_B: begin
          s_d.wb_dat = s_q.duty[1];
        end
        `TPW_OFF_DUTY_C: begin
          s_d.wb_dat = s_q.duty[2];
        end
        `TPW_OFF_STEER: begin
          s_d.wb_dat = {7'h00, s_q.steer};
        end
        `TPW_OFF_STATUS: begin
          s_d.wb_dat[`TPW_STAT_RUN_BIT]  = s_q.run;
          s_d.wb_dat[`TPW_STAT_HALF_BIT] = s_q.half; // [RULE9]
        end
        default: begin
          s_d.wb_dat = 16'h0000;
        end
      endcase
    end

    // Register writes; a write to an unmapped offset is acknowledged and dropped.
    if (wr) begin
      case (wb_adr_i)
        `TPW_OFF_MODE: begin
          if (wb_sel_i[0]) begin
            s_d.dbl = wval[`TPW_MODE_DBL_BIT]; // [RULE4]
          end
        end
        `TPW_OFF_HALF_PER: begin
          s_d.tm = wr16(s_q.tm, wb_dat_i, wb_sel_i); // [RULE19] [RULE20]
          s_d.written[`TPW_WR_TM] = 1'b1;
          if (!s_q.tmr_on) begin
            s_d.tmr_on = 1'b1; // [RULE18]
            s_d.st_cnt = 18'h00000;
          end
        end
        `TPW_OFF_DEAD: begin
          s_d.dt = 10'(wr16({6'h00, s_q.dt}, wb_dat_i, wb_sel_i)); // [RULE2]
        end
        `TPW_OFF_MIN_PULSE: begin
          s_d.mp = wr16(s_q.mp, wb_dat_i, wb_sel_i);
        end
        `TPW_OFF_SYNC_W: begin
          if (wb_sel_i[0]) begin
            s_d.sw = wval[7:0];
          end
        end
        `TPW_OFF_DUTY_A: begin
          s_d.duty[0] = wr16(s_q.duty[0], wb_dat_i, wb_sel_i);
          s_d.written[`TPW_WR_A] = 1'b1;
        end
        `TPW_OFF_DUTY_B: begin
          s_d.duty[1] = wr16(s_q.duty[1], wb_dat_i, wb_sel_i);
          s_d.written[`TPW_WR_B] = 1'b1;
        end
        `TPW_OFF_DUTY_C: begin
          s_d.duty[2] = wr16(s_q.duty[2], wb_dat_i, wb_sel_i);
          s_d.written[`TPW_WR_C] = 1'b1;
        end
        `TPW_OFF_STEER: begin
          s_d.steer = 9'(wr16({7'h00, s_q.steer}, wb_dat_i, wb_sel_i));
        end
        default: begin
          s_d.steer = s_q.steer;
        end
      endcase
    end

    // Before start the main timer only measures the start delay; outputs stay off.
    if (!s_q.run) begin
      if (s_q.tmr_on && !(wr && wb_adr_i == `TPW_OFF_HALF_PER && !s_q.tmr_on)) begin
        if (s_q.st_cnt != 18'h3FFFF) begin
          s_d.st_cnt = s_q.st_cnt + 18'h00001;
        end
      end
      if ((&s_q.written) && s_q.tmr_on && (s_q.st_cnt >= target)) begin // [RULE17] [RULE18]
        s_d      = load_cfg(s_d); // [RULE6] [RULE7]
        s_d.run  = 1'b1;
        s_d.fire = 1'b1;
        s_d.half = 1'b0;
        s_d.cnt  = 16'h0000;
      end
    end else if (!s_q.half) begin
      // First half counts up; a half period is a_tm clocks long.
      if (s_q.cnt >= s_q.a_tm - 16'h0001) begin
        s_d.half = 1'b1; // [RULE9]
        if (s_q.dbl) begin
          s_d      = load_cfg(s_d); // [RULE8] [RULE7] [RULE16]
          s_d.fire = 1'b1;
          s_d.cnt  = s_d.a_tm - 16'h0001;
        end else begin
          s_d.cnt  = s_q.a_tm - 16'h0001; // [RULE13]
        end
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001; // [RULE22]
      end
    end else begin
      // Second half counts down, mirroring the first so the pattern stays centred.
      if (s_q.cnt == 16'h0000) begin
        s_d      = load_cfg(s_d); // [RULE6] [RULE7]
        s_d.fire = 1'b1;
        s_d.half = 1'b0;
        s_d.cnt  = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001; // [RULE22]
      end
    end
  end

  // The block state apart from the reset pipe is one register; reset sets single update and the sync width.
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q      <= '0; // [RULE5]
      s_q.sw   <= `TPW_SYNC_W_RST; // [RULE11]
      s_q.a_sw <= `TPW_SYNC_W_RST; // [RULE11]
    end else begin
      s_q <= s_d;
    end
  end

  // Three identical comparators, each fed by its own working duty value.
  for (genvar i = 0; i < 3; i++) begin : g_phase
    tpw_phase #(
      .CW (16),
      .DW (10)
    ) u_phase (
      .clk_sys (clk_sys),
      .rst_n   (rst_sync_n),
      .run     (s_q.run),
      .cnt     (s_q.cnt),
      .tm      (s_q.a_tm),
      .duty    (s_q.a_duty[i]), // [RULE12]
      .dt      (s_q.a_dt),
      .high_q  (hi_w[i]),
      .low_q   (lo_w[i])
    );
  end

  // Sync pulse follows each load by one clock; its width uses the value just loaded.
  tpw_sync_gen u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .fire    (s_q.fire),
    .width   (s_q.a_sw), // [RULE10]
    .sync_q  (period_sync_pulse),
    .irq_q   (sync_irq) // [RULE21]
  );

  // Outputs are flops of this module or of its four sub-block instances.
  assign wb_ack_o         = s_q.wb_ack;
  assign wb_dat_o         = {16'h0000, s_q.wb_dat};
  assign phase_a_high_out = hi_w[0];
  assign phase_a_low_out  = lo_w[0];
  assign phase_b_high_out = hi_w[1];
  assign phase_b_low_out  = lo_w[1];
  assign phase_c_high_out = hi_w[2];
  assign phase_c_low_out  = lo_w[2];
  assign steer_active     = s_q.a_steer; // [RULE7]

endmodule

// ### verif/tb_tpw_timing_unit.sv
// Self-checking bench of the PWM timing unit against an integer model.
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tb_tpw_timing_unit;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] dat_o, rdat;
  logic        ack, sync, irq;
  logic [5:0]  g;
  logic [8:0]  steer;
  int          fails = 0, checked = 0, cyc_n = 0, tk, t0, shorts, on_n [6];

  // Free-running clock and edge counter; the counter is read before each edge lands.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;

  tpw_timing_unit tpw_timing_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .phase_a_high_out(g[0]), .phase_a_low_out(g[1]),
    .phase_b_high_out(g[2]), .phase_b_low_out(g[3]), .phase_c_high_out(g[4]),
    .phase_c_low_out(g[5]), .period_sync_pulse(sync), .sync_irq(irq), .steer_active(steer));
  tpw_gate_model tpw_gate_model_i (.clk_sys(clk_sys), .gate(g), .on_n(on_n), .shorts(shorts));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input int exp);
    checked++;
    if (seen !== 32'(exp)) begin
      fails++;
      $display("unexpected %s: expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  function automatic int clamp(input int v, input int hi);
    return v < 0 ? 0 : (v > hi ? hi : v);
  endfunction

  // Classic Wishbone cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= 32'(d);
    sel  <= 4'h3;
    @(posedge clk_sys iff ack);
    rdat = dat_o;
    tk   = cyc_n; // Read before this edge lands, so it names the taking edge.
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask

  task automatic wsync();
    @(posedge clk_sys iff !sync);
    @(posedge clk_sys iff sync);
  endtask

  task automatic rst();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // One single-update setting, measured over a whole period after it is surely loaded.
  task automatic single(input int tm, input int dt, input int sw);
    int d [3], st, w, n0 [6];
    st = $urandom_range(511);
    bus(1'b1, `TPW_OFF_HALF_PER, tm);
    bus(1'b1, `TPW_OFF_DEAD, dt);
    if (sw >= 0) bus(1'b1, `TPW_OFF_SYNC_W, sw);
    bus(1'b1, `TPW_OFF_STEER, st);
    for (int p = 0; p < 3; p++) begin
      d[p] = $urandom_range(tm + 8);
      bus(1'b1, 8'(`TPW_OFF_DUTY_A + 4 * p), d[p]);
    end
    repeat (3) wsync();
    t0 = cyc_n;
    n0 = on_n;
    w = 0;
    while (sync) begin
      w++;
      @(posedge clk_sys);
    end
    wsync();
    chk("sync width", 32'(w), sw < 0 ? 40 : sw + 1);
    chk("period", 32'(cyc_n - t0), 2 * tm);
    chk("steering", 32'(steer), st);
    for (int p = 0; p < 3; p++) begin
      chk("high on", on_n[2*p] - n0[2*p], clamp(2 * (d[p] - dt), 2 * tm));
      chk("low on", on_n[2*p+1] - n0[2*p+1], clamp(2 * (tm - d[p] - dt), 2 * tm));
    end
  endtask

  // Double update: each half carries its own period and duty.
  task automatic dbl();
    int tmh [2], d [2], half, tp, n1 [6], np [6];
    for (int h = 0; h < 2; h++) begin
      tmh[h] = 40 + $urandom_range(20);
      d[h]   = 3 + $urandom_range(tmh[h] - 6);
    end
    bus(1'b1, `TPW_OFF_MODE, 32'h40);
    bus(1'b0, `TPW_OFF_MODE, 0);
    chk("mode", rdat, 32'h40);
    bus(1'b1, `TPW_OFF_SYNC_W, 4);
    bus(1'b1, `TPW_OFF_DEAD, 3);
    bus(1'b1, `TPW_OFF_HALF_PER, tmh[0]);
    t0 = tk;
    for (int p = 0; p < 3; p++) bus(1'b1, 8'(`TPW_OFF_DUTY_A + 4 * p), d[0]);
    wsync();
    chk("first sync", 32'(cyc_n - t0), tmh[0]);
    for (int k = 0; k < 9; k++) begin
      t0 = cyc_n;
      n1 = on_n;
      if (k > 1) chk("half length", 32'(t0 - tp), tmh[half]);
      bus(1'b0, `TPW_OFF_STATUS, 0);
      if (k > 0) chk("half bit", 32'(rdat[3]), half ^ 1);
      half = int'(rdat[3]);
      if (k > 2 && half == 0) begin
        chk("dbl high", n1[0] - np[0], d[0] + d[1] - 6);
        chk("dbl low", n1[5] - np[5], tmh[0] + tmh[1] - d[0] - d[1] - 6);
      end
      if (half == 0) np = n1;
      tp = t0;
      bus(1'b1, `TPW_OFF_HALF_PER, tmh[half^1]);
      for (int p = 0; p < 3; p++) bus(1'b1, 8'(`TPW_OFF_DUTY_A + 4 * p), d[half^1]);
      wsync();
    end
  endtask

  // Watchdog: the whole run needs well under this span.
  initial begin
    #400000;
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(78));
    rst();
    bus(1'b0, `TPW_OFF_MODE, 0);
    chk("mode reset", rdat, 0);
    bus(1'b0, `TPW_OFF_SYNC_W, 0);
    chk("sync width reset", rdat, 32'h27);
    bus(1'b1, `TPW_OFF_DEAD, 32'hFFFF);
    bus(1'b0, `TPW_OFF_DEAD, 0);
    chk("dead time", rdat, 32'h3FF);
    bus(1'b1, `TPW_OFF_MIN_PULSE, 32'h1234);
    bus(1'b0, `TPW_OFF_MIN_PULSE, 0);
    chk("min pulse", rdat, 32'h1234);
    bus(1'b1, 8'h3C, 32'h5A5A);
    bus(1'b0, 8'h3C, 0);
    chk("unmapped", rdat, 0);
    bus(1'b1, `TPW_OFF_HALF_PER, 60);
    t0 = tk;
    bus(1'b0, `TPW_OFF_STATUS, 0);
    chk("running", 32'(rdat[0]), 0);
    for (int p = 0; p < 3; p++) bus(1'b1, 8'(`TPW_OFF_DUTY_A + 4 * p), 10 * p);
    wsync();
    chk("first sync", 32'(cyc_n - t0), 90);
    bus(1'b0, `TPW_OFF_STATUS, 0);
    chk("running after start", 32'(rdat[0]), 1);
    for (int i = 0; i < 6; i++) begin
      single(48 + $urandom_range(31), i == 0 ? 0 : (i == 5 ? 1023 : $urandom_range(8)),
             i == 0 ? -1 : $urandom_range(20));
    end
    rst();
    dbl();
    chk("shoot-through", 32'(shorts), 0);
    wrap_up();
  end
endmodule

// ### verif/tpw_gate_model.sv
// Gate driver model: integrates the on-time of each output and counts shoot-through.
`timescale 1ns/1ps
module tpw_gate_model (
  input  wire logic       clk_sys,
  input  wire logic [5:0] gate,
  output int              on_n [6],
  output int              shorts
);
  // A pair that is on together would short the dc link, so each such cycle is counted.
  always @(posedge clk_sys) begin
    for (int i = 0; i < 6; i++) begin
      if (gate[i]) on_n[i] <= on_n[i] + 1;
    end
    if ((gate[0] && gate[1]) || (gate[2] && gate[3]) || (gate[4] && gate[5])) shorts <= shorts + 1;
  end
endmodule

// ### verif/tpw_timing_unit_asserts.sv
// Port-level assertions of the PWM timing unit, bound to its top module.
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_timing_unit_asserts #(
  parameter int AW = 8
) (
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          phase_a_high_out,
  input wire logic          phase_a_low_out,
  input wire logic          phase_b_high_out,
  input wire logic          phase_b_low_out,
  input wire logic          phase_c_high_out,
  input wire logic          phase_c_low_out,
  input wire logic          period_sync_pulse,
  input wire logic          sync_irq,
  input wire logic [8:0]    steer_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [3:0] wr_q;
  logic [7:0] sw_q;
  logic [7:0] sw_p;
  logic [7:0] lat_q;
  logic [8:0] len_q;
  wire        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire        outs = phase_a_high_out || phase_a_low_out || phase_b_high_out
                     || phase_b_low_out || phase_c_high_out || phase_c_low_out;
  // Shadows of the written flags and sync width; width is latched as the pulse starts.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 4'h0;
      sw_q  <= 8'h27;
      sw_p  <= 8'h27;
      lat_q <= 8'h27;
      len_q <= 9'h000;
    end else begin
      if (wr && wb_adr_i == `TPW_OFF_HALF_PER) wr_q[0] <= 1'b1;
      for (int p = 0; p < 3; p++) begin
        if (wr && wb_adr_i == 8'(`TPW_OFF_DUTY_A + 4 * p)) wr_q[p+1] <= 1'b1;
      end
      if (wr && wb_adr_i == `TPW_OFF_SYNC_W) sw_q <= wb_dat_i[7:0];
      // The load precedes the first high sample by two edges, so the width is taken delayed.
      sw_p <= sw_q;
      if (period_sync_pulse && len_q == 9'h000) lat_q <= sw_p;
      len_q <= period_sync_pulse ? len_q + 9'h001 : 9'h000;
    end
  end
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse_end; $fell(period_sync_pulse); endsequence
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_dat;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 && (wb_we_i || wb_adr_i <= 8'h24 || wb_dat_o == 32'h0);
  endproperty
  a_dat: assert property (p_dat) else $error("read data out of range");
  property p_pair;
    !(phase_a_high_out && phase_a_low_out) && !(phase_b_high_out && phase_b_low_out)
      && !(phase_c_high_out && phase_c_low_out);
  endproperty
  a_pair: assert property (p_pair) else $error("pair outputs on together");
  property p_irq; sync_irq == $rose(period_sync_pulse); endproperty
  a_irq: assert property (p_irq) else $error("irq not tied to sync rise");
  property p_steer; $changed(steer_active) |-> ##[0:1] sync_irq; endproperty
  a_steer: assert property (p_steer) else $error("steering changed off sync");
  property p_width; s_pulse_end |-> len_q == 9'(lat_q) + 9'h001; endproperty
  a_width: assert property (p_width) else $error("sync pulse width wrong");
  property p_idle; wr_q != 4'hF |-> !period_sync_pulse && !outs; endproperty
  a_idle: assert property (p_idle) else $error("activity before setup");
endmodule

bind tpw_timing_unit tpw_timing_unit_asserts #(.AW(AW)) tpw_timing_unit_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_high_out(phase_a_high_out),
  .phase_a_low_out(phase_a_low_out), .phase_b_high_out(phase_b_high_out),
  .phase_b_low_out(phase_b_low_out), .phase_c_high_out(phase_c_high_out),
  .phase_c_low_out(phase_c_low_out), .period_sync_pulse(period_sync_pulse),
  .sync_irq(sync_irq), .steer_active(steer_active));
